// >>> rtl/fault_handler.sv
/*
  Runtime fault class handler with on-line command acceptance.
  Assumes faults, commands and buttons arrive as synchronous one-cycle pulses.
*/
// Overview of operation
// RL1 - Class 0 stops, locks out running; only reboot clears it.
// RL2 - Classes 1 to 3 stop and log; running may resume later.
// RL3 - Class 4 keeps running, logs, sets resource fault word bit.
// RL4 - Class 5 keeps running, halts axis, latches signal word, logs.
// RL5 - Classes 0 to 4 flash their code on the display.
// RL6 - Log holds sixteen: first eight and last eight.
// RL7 - Address button steps display to the next stored entry.
// RL8 - Controller reset or restart purges all but class 0 entries.
// RL9 - Host reads any entry with class and detail code.
// RL10 - Host selects mode 60 or 70 for serial commands.
// RL11 - Host selects mode 63 or 73 for CAN commands.
// RL12 - Host sets node address via setting 61 or 71.
// RL13 - Host sets bit rate via 62 or 72 where needed.
// RL14 - Each received command executes at once, one at a time.
// RL15 - Host initialises axis power before any movement command.
// RL16 - Command parameters live in volatile registers only.
// RL17 - Commands are accepted in application mode too.
// RL18 - Timeout command is rejected on the excluded fieldbus variant.
// RL19 - Commands clear faults and signals; reads return signals and status.
// RL20 - Continue resumes only when no class 0 fault exists.
// RL21 - Stopped state halts program, drive off, outputs disabled.
// RL22 - When full, new faults overwrite oldest of the late group.
// RL23 - Simultaneous faults get the most severe response.
`timescale 1ns/100ps
module fault_handler
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [5:0] fault_req,
  input wire logic [fault_pkg::CODE_W-1:0] fault_code,
  input wire logic [fault_pkg::SIG_W-1:0] active_signal,
  input wire logic [fault_pkg::FW_W-1:0] fault_word_bit,
  input wire logic ctl_reset,
  input wire logic prog_restart,
  input wire logic adr_press,
  input wire logic [fault_pkg::CODE_W-1:0] mode_setting,
  input wire logic no_timeout_variant,
  input wire logic cmd_valid,
  input wire logic [fault_pkg::CMD_W-1:0] cmd_op,
  input wire logic [15:0] cmd_param,
  input wire logic [fault_pkg::IDX_W-1:0] host_idx,
  output logic [fault_pkg::CODE_W-1:0] disp_code,
  output logic disp_flash,
  output logic run_state,
  output logic drive_enable,
  output logic outputs_enable,
  output logic system_lock,
  output logic axis_halt,
  output logic [fault_pkg::FW_W-1:0] fault_word,
  output logic [fault_pkg::SIG_W-1:0] signal_word,
  output logic [fault_pkg::ENTRY_W-1:0] host_entry,
  output logic host_entry_valid,
  output logic cmd_done,
  output logic cmd_reject,
  output logic [15:0] cmd_rdata,
  output logic [15:0] move_param,
  output logic move_start
);
  import fault_pkg::*;

  ctl_state_t state_q;
  logic [CLASS_W-1:0] worst_cls;
  logic any_fault, stop_fault, purge, cmd_ok, is_online;
  logic [ENTRY_W-1:0] mem_entry;
  logic mem_vld;
  logic [IDX_W:0] mem_cnt;
  logic [IDX_W-1:0] disp_idx_q;
  logic [FLASH_W-1:0] flash_cnt_q;
  logic flash_q, showing_q, power_init_q;
  logic [CODE_W-1:0] disp_code_q;

  // Lowest class number is the most severe
  function automatic logic [CLASS_W-1:0] worst(input logic [5:0] req);
    logic [CLASS_W-1:0] c;
    c = CLS_SIGNAL;
    for (int i = 5; i >= 0; i--) begin
      if (req[i]) begin
        c = CLASS_W'(i);
      end
    end
    return c;
  endfunction

  assign any_fault = |fault_req;
  assign worst_cls = worst(fault_req); // RL23
  assign stop_fault = |fault_req[3:0];
  assign purge = ctl_reset | prog_restart; // RL8
  assign is_online = mode_setting == MODE_SER_A || mode_setting == MODE_SER_B ||
    mode_setting == MODE_CAN_A || mode_setting == MODE_CAN_B ||
    mode_setting == MODE_APP; // RL17
  assign cmd_ok = cmd_valid && is_online;

  fault_memory u_mem (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(any_fault),
    .wr_entry({worst_cls, fault_code}),
    .purge(purge),
    .rd_idx(adr_press ? disp_idx_q : host_idx),
    .rd_entry(mem_entry),
    .rd_valid(mem_vld),
    .count(mem_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Controller state

  // Stop wins over continue so a new fault is never masked
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_STOP;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (stop_fault || purge || (cmd_ok && cmd_op == CMD_STOP)) begin
            state_q <= ST_STOP; // RL1 RL2
          end
        end
        ST_STOP: begin
          if (cmd_ok && cmd_op == CMD_CONT && !system_lock && !stop_fault) begin
            state_q <= ST_RUN; // RL20 RL2
          end
        end
        default: state_q <= ST_STOP;
      endcase
    end
  end

  // Class 0 lock; only sys_rst (boot) releases it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      system_lock <= 1'b0;
    end else if (fault_req[0]) begin
      system_lock <= 1'b1; // RL1
    end
  end

  // Stopped state gates drive and outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_state <= 1'b0;
      drive_enable <= 1'b0;
      outputs_enable <= 1'b0;
    end else begin
      run_state <= state_q == ST_RUN;
      drive_enable <= state_q == ST_RUN && power_init_q; // RL21
      outputs_enable <= state_q == ST_RUN; // RL21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resource words; a new event wins over a clear in the same cycle

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fault_word <= '0;
    end else begin
      fault_word <= (fault_word & ~{FW_W{purge || (cmd_ok && cmd_op == CMD_FAULT_CLR)}}) |
        (fault_req[4] ? fault_word_bit : '0); // RL3 RL19
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      signal_word <= '0;
      axis_halt <= 1'b0;
    end else begin
      signal_word <= (signal_word & ~{SIG_W{cmd_ok && cmd_op == CMD_SIG_CLR}}) |
        (fault_req[5] ? active_signal : '0); // RL4 RL19
      if (fault_req[5] && |active_signal) begin
        axis_halt <= 1'b1; // RL4
      end else if (cmd_ok && (cmd_op == CMD_SIG_CLR || cmd_op == CMD_MOVE)) begin
        axis_halt <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status display

  // Flash timer free-runs; cheap and keeps all digits in phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q == FLASH_W'(FLASH_CYC - 1)) begin
      flash_cnt_q <= '0;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 1'b1;
    end
  end

  // New class 0..4 fault shows its code; address button steps the log
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      disp_code_q <= DISP_RESET;
      showing_q <= 1'b0;
      disp_idx_q <= '0;
    end else if (any_fault && worst_cls != CLS_SIGNAL) begin
      disp_code_q <= fault_code; // RL5
      showing_q <= 1'b1;
    end else if (adr_press && mem_cnt != '0) begin
      disp_idx_q <= (disp_idx_q + 1'b1 >= mem_cnt[IDX_W-1:0] &&
        mem_cnt != (IDX_W+1)'(MEM_DEPTH)) ? '0 : disp_idx_q + 1'b1; // RL7
      disp_code_q <= mem_entry[CODE_W-1:0];
      showing_q <= mem_vld;
    end else if (purge && !system_lock) begin
      showing_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      disp_code <= DISP_RESET;
      disp_flash <= 1'b0;
    end else begin
      disp_code <= showing_q ? disp_code_q : mode_setting;
      disp_flash <= showing_q & flash_q; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host read port and on-line commands

  // Host read follows host_idx one cycle late; the button borrows the port
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_entry <= '0;
      host_entry_valid <= 1'b0;
    end else begin
      host_entry <= mem_entry; // RL9
      host_entry_valid <= mem_vld && !adr_press; // Stale while the display reads
    end
  end

  // One command per cycle, executed on receipt; parameters are volatile flops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_rdata <= '0;
      move_param <= PARAM_RESET; // RL16
      move_start <= 1'b0;
      power_init_q <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      move_start <= 1'b0;
      if (cmd_valid && !cmd_ok) begin
        cmd_reject <= 1'b1;
      end else if (cmd_ok) begin
        cmd_done <= 1'b1; // RL14
        case (cmd_op)
          CMD_INIT: power_init_q <= 1'b1;
          CMD_MOVE: begin
            move_param <= cmd_param; // RL16
            move_start <= power_init_q && state_q == ST_RUN;
          end
          CMD_SIG_RD: cmd_rdata <= {8'h00, signal_word}; // RL19
          CMD_STAT_RD: cmd_rdata <= {11'h000, system_lock, axis_halt, 2'h0,
            state_q == ST_RUN}; // RL19
          CMD_FW_RD: cmd_rdata <= fault_word;
          CMD_TIMEOUT: begin
            if (no_timeout_variant) begin
              cmd_done <= 1'b0;
              cmd_reject <= 1'b1; // RL18
            end
          end
          default: cmd_rdata <= cmd_rdata;
        endcase
      end
    end
  end
endmodule

// >>> inc/fault_pkg.sv
/*
  Shared constants and types for the runtime fault handler.
  Assumes a single 20 MHz clock domain and synchronous inputs.
*/
package fault_pkg;
  localparam int CLASS_W = 3;
  localparam int CODE_W = 8;
  localparam int ENTRY_W = CLASS_W + CODE_W;
  localparam int MEM_DEPTH = 16;
  localparam int HALF_DEPTH = 8;
  localparam int IDX_W = 4;
  localparam int SIG_W = 8;
  localparam int FW_W = 16;
  localparam logic [CLASS_W-1:0] CLS_SYSTEM = 3'h0;
  localparam logic [CLASS_W-1:0] CLS_FATAL = 3'h1;
  localparam logic [CLASS_W-1:0] CLS_NONFATAL = 3'h2;
  localparam logic [CLASS_W-1:0] CLS_SETTING = 3'h3;
  localparam logic [CLASS_W-1:0] CLS_PROG = 3'h4;
  localparam logic [CLASS_W-1:0] CLS_SIGNAL = 3'h5;
  localparam logic [CODE_W-1:0] DISP_RESET = 8'h00;
  // Display mode codes for on-line operation
  localparam logic [CODE_W-1:0] MODE_SER_A = 8'h60;
  localparam logic [CODE_W-1:0] MODE_SER_B = 8'h70;
  localparam logic [CODE_W-1:0] MODE_CAN_A = 8'h63;
  localparam logic [CODE_W-1:0] MODE_CAN_B = 8'h73;
  localparam logic [CODE_W-1:0] MODE_APP = 8'h01;
  // Flash half period: 250 ms at 50 ns per cycle
  localparam int FLASH_MS = 250;
  localparam int CLK_NS = 50;
  localparam int FLASH_CYC = FLASH_MS * 1000000 / CLK_NS;
  localparam int FLASH_W = 24;
  // On-line command codes
  localparam int CMD_W = 6;
  localparam logic [CMD_W-1:0] CMD_INIT = 6'h01;
  localparam logic [CMD_W-1:0] CMD_FAULT_CLR = 6'h02;
  localparam logic [CMD_W-1:0] CMD_SIG_CLR = 6'h03;
  localparam logic [CMD_W-1:0] CMD_SIG_RD = 6'h04;
  localparam logic [CMD_W-1:0] CMD_STAT_RD = 6'h05;
  localparam logic [CMD_W-1:0] CMD_TIMEOUT = 6'h06;
  localparam logic [CMD_W-1:0] CMD_MOVE = 6'h07;
  localparam logic [CMD_W-1:0] CMD_CONT = 6'h08;
  localparam logic [CMD_W-1:0] CMD_STOP = 6'h09;
  localparam logic [CMD_W-1:0] CMD_FW_RD = 6'h0a;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN = 2'b10
  } ctl_state_t;
endpackage

// >>> rtl/fault_memory.sv
/*
  Sixteen-entry fault log: first eight kept, last eight as a ring.
  Assumes one write request per cycle at most, synchronous to ref_clk.
*/
`timescale 1ns/100ps
module fault_memory
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [fault_pkg::ENTRY_W-1:0] wr_entry,
  input wire logic purge,
  input wire logic [fault_pkg::IDX_W-1:0] rd_idx,
  output logic [fault_pkg::ENTRY_W-1:0] rd_entry,
  output logic rd_valid,
  output logic [fault_pkg::IDX_W:0] count
);
  logic [ENTRY_W-1:0] mem_q [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] vld_q;
  logic [IDX_W-1:0] wptr_q;
  logic [IDX_W:0] cnt_q;
  logic [IDX_W-1:0] slot;

  // Early half fills first, then the late half wraps on itself
  assign slot = (cnt_q < IDX_W'(HALF_DEPTH)) ? cnt_q[IDX_W-1:0] : wptr_q; // RL6 RL22

  // Entry storage; class 0 entries survive a purge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vld_q <= '0;
    end else begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        if (wr_en && slot == IDX_W'(i)) begin
          mem_q[i] <= wr_entry;
          vld_q[i] <= 1'b1;
        end else if (purge && mem_q[i][ENTRY_W-1:CODE_W] != CLS_SYSTEM) begin
          vld_q[i] <= 1'b0; // RL8
        end
      end
    end
  end

  // Count and ring pointer; purge keeps the log shape, count and pointer unchanged
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= '0;
      wptr_q <= IDX_W'(HALF_DEPTH);
    end else if (wr_en) begin
      if (cnt_q < (IDX_W+1)'(MEM_DEPTH)) begin
        cnt_q <= cnt_q + 1'b1;
      end
      if (cnt_q >= (IDX_W+1)'(HALF_DEPTH)) begin
        wptr_q <= (wptr_q == IDX_W'(MEM_DEPTH-1)) ? IDX_W'(HALF_DEPTH) : wptr_q + 1'b1; // RL22
      end
    end
  end

  assign rd_entry = mem_q[rd_idx];
  assign rd_valid = vld_q[rd_idx];
  assign count = cnt_q;
endmodule

// >>> sim/fault_handler_sva.sv
/* Port assertions for fault_handler.
   Assumes one clock domain; bound to every instance. */
`timescale 1ns/100ps
module fault_handler_sva
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [5:0] fault_req,
  input wire logic [7:0] fault_code,
  input wire logic [7:0] active_signal,
  input wire logic [15:0] fault_word_bit,
  input wire logic ctl_reset,
  input wire logic prog_restart,
  input wire logic adr_press,
  input wire logic [7:0] mode_setting,
  input wire logic no_timeout_variant,
  input wire logic cmd_valid,
  input wire logic [5:0] cmd_op,
  input wire logic [7:0] disp_code,
  input wire logic run_state,
  input wire logic drive_enable,
  input wire logic outputs_enable,
  input wire logic system_lock,
  input wire logic axis_halt,
  input wire logic [15:0] fault_word,
  input wire logic cmd_done,
  input wire logic cmd_reject
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [15:0] fw_q;
  logic quiet;
  logic mode_ok;
  ////////////////////////////////////////////////////////////////
  // Nothing else that could move the state this cycle
  assign quiet = !cmd_valid && !ctl_reset && !prog_restart && fault_req[3:0] == 4'h0;
  assign mode_ok = mode_setting inside {MODE_APP, MODE_SER_A, MODE_SER_B,
    MODE_CAN_A, MODE_CAN_B};
  // Held copy, since the word may settle one cycle late
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fw_q <= 16'h0000;
    end else if (fault_req[4]) begin
      fw_q <= fault_word_bit;
    end
  end
  sequence s_soft;
    quiet ##1 (run_state && fault_req[5:4] != 2'b00 && quiet) ##1 quiet;
  endsequence
  sequence s_hard;
    fault_req[3:0] != 4'h0 && !cmd_valid;
  endsequence
  ////////////////////////////////////////////////////////////////
  cls0_lock_a: assert property (fault_req[0] |-> ##[1:2] system_lock)
    else $error("class 0 fault did not lock");
  lock_run_a: assert property (system_lock && $past(system_lock) |-> !run_state)
    else $error("running while locked");
  hard_stop_a: assert property (s_hard |-> ##2 !run_state)
    else $error("fault did not stop");
  stop_outputs_a: assert property (!run_state |-> !drive_enable && !outputs_enable)
    else $error("outputs live while stopped");
  soft_run_a: assert property (s_soft |-> ##1 run_state)
    else $error("soft fault stopped the program");
  word_set_a: assert property (fault_req[4] |-> ##[1:2] (fault_word & fw_q) == fw_q)
    else $error("fault word bit missing");
  sig_halt_a: assert property (fault_req[5] && active_signal != 8'h00 |-> ##[1:2] axis_halt)
    else $error("signal event did not halt axis");
  flash_code_a: assert property (fault_req[4:0] != 5'h00 && !adr_press && !ctl_reset
    && !prog_restart |-> ##2 disp_code == $past(fault_code, 2))
    else $error("display code wrong");
  cmd_answer_a: assert property (cmd_valid && !(cmd_op == CMD_CONT && system_lock)
    |=> cmd_done != cmd_reject)
    else $error("command not answered once");
  bad_mode_a: assert property (cmd_valid && !mode_ok |=> cmd_reject)
    else $error("command taken in wrong mode");
  timeout_ref_a: assert property (cmd_valid && cmd_op == CMD_TIMEOUT
    && no_timeout_variant |=> cmd_reject)
    else $error("timeout command not refused");
endmodule
bind fault_handler fault_handler_sva sva_u (.ref_clk, .sys_rst, .fault_req, .fault_code,
  .active_signal, .fault_word_bit, .ctl_reset, .prog_restart, .adr_press, .mode_setting,
  .no_timeout_variant, .cmd_valid, .cmd_op, .disp_code, .run_state, .drive_enable,
  .outputs_enable, .system_lock, .axis_halt, .fault_word, .cmd_done, .cmd_reject);

// >>> sim/host_model.sv
/* Host side of the on-line command port.
   Assumes the handler answers within a few clocks. */
`timescale 1ns/100ps
module host_model
  import fault_pkg::*;
(
  input wire logic ref_clk,
  input wire logic cmd_done,
  input wire logic cmd_reject,
  output logic cmd_valid,
  output logic [fault_pkg::CMD_W-1:0] cmd_op,
  output logic [15:0] cmd_param,
  output logic [fault_pkg::CODE_W-1:0] mode_setting
);
  // Mode is chosen before any command goes out
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 6'h00;
    cmd_param = 16'h0000;
    mode_setting = MODE_APP;
  end
  task automatic set_mode(input logic [7:0] m);
    @(posedge ref_clk);
    mode_setting <= m;
  endtask
  // Node address, then bit rate, then the working mode
  task automatic configure(input logic [7:0] m);
    @(posedge ref_clk);
    mode_setting <= (m[7:4] == 4'h6) ? 8'h61 : 8'h71;
    @(posedge ref_clk);
    mode_setting <= (m[7:4] == 4'h6) ? 8'h62 : 8'h72;
    @(posedge ref_clk);
    mode_setting <= m;
  endtask
  // One pulse, then junk on the released fields and a bounded wait
  task automatic send(input logic [5:0] op, input logic [15:0] p, output logic [1:0] r);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_param <= p;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_op <= ~op;
    cmd_param <= ~p;
    r = 2'b00;
    for (int i = 0; i < 4 && r == 2'b00; i++) begin
      #1;
      r = {cmd_reject, cmd_done};
      if (r == 2'b00) @(posedge ref_clk);
    end
  endtask
endmodule

// >>> sim/runtime_error_class_handler_test.sv
/* Self-checking bench for fault_handler.
   Assumes host_model drives the command port. */
`timescale 1ns/100ps
module runtime_error_class_handler_test;
  import fault_pkg::*;
  logic ref_clk, sys_rst, ctl_reset, prog_restart, adr_press, no_timeout_variant;
  logic [5:0] fault_req, cmd_op;
  logic [7:0] fault_code, active_signal, mode_setting, disp_code, signal_word;
  logic [15:0] fault_word_bit, cmd_param, fault_word, cmd_rdata, move_param;
  logic [3:0] host_idx;
  logic [10:0] host_entry;
  logic disp_flash, run_state, drive_enable, outputs_enable, system_lock, axis_halt;
  logic host_entry_valid, cmd_done, cmd_reject, cmd_valid, move_start;
  int miscompares, n_tests;
  logic [1:0] r;
  fault_handler dut_u (.ref_clk, .sys_rst, .fault_req, .fault_code, .active_signal,
    .fault_word_bit, .ctl_reset, .prog_restart, .adr_press, .mode_setting,
    .no_timeout_variant, .cmd_valid, .cmd_op, .cmd_param, .host_idx, .disp_code,
    .disp_flash, .run_state, .drive_enable, .outputs_enable, .system_lock, .axis_halt,
    .fault_word, .signal_word, .host_entry, .host_entry_valid, .cmd_done, .cmd_reject,
    .cmd_rdata, .move_param, .move_start);
  host_model host_u (.ref_clk, .cmd_done, .cmd_reject, .cmd_valid, .cmd_op, .cmd_param,
    .mode_setting);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // A lost answer ends the run, nothing later would be meaningful
  task automatic cmd(input logic [5:0] op, input logic [1:0] exp);
    host_u.send(op, 16'h0000, r);
    chk({14'h0, r}, {14'h0, exp});
    if (r === 2'b00) close_out();
  endtask
  task automatic fault(input logic [5:0] m, input logic [7:0] c);
    @(posedge ref_clk);
    fault_req <= m;
    fault_code <= c;
    @(posedge ref_clk);
    fault_req <= 6'h00;
    wt(2);
  endtask
  task automatic reboot();
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic go_run();
    cmd(CMD_CONT, 2'b01);
    wt(1);
    chk(run_state, 1'b1);
  endtask
  task automatic press(input logic [7:0] exp);
    @(posedge ref_clk);
    adr_press <= 1'b1;
    @(posedge ref_clk);
    adr_press <= 1'b0;
    wt(1);
    chk(disp_code, exp);
  endtask
  task automatic rd(input int k);
    @(posedge ref_clk);
    host_idx <= 4'(k);
    wt(2);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_cmds();
    logic [7:0] modes [5] = '{8'h60, 8'h70, 8'h63, 8'h73, 8'h01};
    foreach (modes[i]) begin
      host_u.configure(modes[i]);
      cmd(CMD_STAT_RD, 2'b01);
    end
    host_u.set_mode(8'h55);
    cmd(CMD_STAT_RD, 2'b10);
    host_u.set_mode(MODE_APP);
    @(posedge ref_clk);
    no_timeout_variant <= 1'b1;
    cmd(CMD_TIMEOUT, 2'b10);
    @(posedge ref_clk);
    no_timeout_variant <= 1'b0;
    cmd(CMD_TIMEOUT, 2'b01);
  endtask
  task automatic t_classes();
    cmd(CMD_INIT, 2'b01);
    for (int c = 1; c < 4; c++) begin
      go_run();
      chk(drive_enable, 1'b1);
      fault(6'(1 << c), 8'(c + 16));
      chk(run_state, 1'b0);
      chk(outputs_enable, 1'b0);
      chk(disp_code, 16'(c + 16));
      chk(disp_flash, 1'b0); // First half period is dark
    end
    go_run();
    host_u.send(CMD_MOVE, 16'h1234, r);
    chk({14'h0, r}, 16'h0001);
    chk(move_start, 1'b1);
    chk(move_param, 16'h1234);
  endtask
  task automatic t_prog();
    fault(6'h10, 8'h44);
    chk(run_state, 1'b1);
    chk(fault_word, 16'h0204);
    chk(disp_code, 16'h0044);
    fault(6'h20, 8'h55);
    chk(run_state, 1'b1);
    chk(signal_word, 16'h0021);
    chk(axis_halt, 1'b1);
    cmd(CMD_STAT_RD, 2'b01);
    chk(cmd_rdata, 16'h0009);
    cmd(CMD_SIG_RD, 2'b01);
    chk(cmd_rdata, 16'h0021);
    cmd(CMD_SIG_CLR, 2'b01);
    wt(1);
    chk(signal_word, 16'h0000);
    cmd(CMD_FW_RD, 2'b01);
    chk(cmd_rdata, 16'h0204);
    cmd(CMD_FAULT_CLR, 2'b01);
    wt(1);
    chk(fault_word, 16'h0000);
    fault(6'h12, 8'h66);
    chk(run_state, 1'b0);
    go_run();
    cmd(CMD_STOP, 2'b01);
    wt(1);
    chk(run_state, 1'b0);
  endtask
  // Twenty faults: first eight stay, ring slots 8..11 wrap over
  task automatic t_log();
    int n;
    reboot();
    for (int i = 0; i < 20; i++) fault(6'h04, 8'(i + 128));
    for (int k = 0; k < 16; k++) begin
      n = (k >= 8 && k < 12) ? k + 8 : k;
      rd(k);
      chk(host_entry, {5'h00, 3'h2, 8'(n + 128)});
      chk(host_entry_valid, 1'b1);
    end
    press(8'h80);
    press(8'h81);
  endtask
  task automatic t_purge();
    reboot();
    fault(6'h04, 8'ha1);
    fault(6'h01, 8'hb2);
    chk(system_lock, 1'b1);
    host_u.send(CMD_CONT, 16'h0000, r);
    wt(2);
    chk(run_state, 1'b0);
    @(posedge ref_clk);
    ctl_reset <= 1'b1;
    @(posedge ref_clk);
    ctl_reset <= 1'b0;
    rd(0);
    chk(host_entry_valid, 1'b0);
    rd(1);
    chk(host_entry_valid, 1'b1);
    chk(host_entry, 16'h00b2);
    chk(system_lock, 1'b1);
    fault(6'h04, 8'hc3);
    @(posedge ref_clk);
    prog_restart <= 1'b1;
    @(posedge ref_clk);
    prog_restart <= 1'b0;
    rd(2);
    chk(host_entry_valid, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Inputs idle until a scenario pulses them
  initial begin
    sys_rst = 1'b1;
    ctl_reset = 1'b0;
    prog_restart = 1'b0;
    adr_press = 1'b0;
    no_timeout_variant = 1'b0;
    fault_req = 6'h00;
    fault_code = 8'h00;
    active_signal = 8'h21;
    fault_word_bit = 16'h0204;
    host_idx = 4'h0;
    miscompares = 0;
    n_tests = 0;
    reboot();
    t_cmds();
    t_classes();
    t_prog();
    t_log();
    t_purge();
    close_out();
  end
endmodule
